// ===== mfic_pkg.sv
// Package of constants for the multifunction interrupt controller
package mfic_pkg;
    localparam logic [7:0] ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] ADDR_GROUP = 8'h01;
    localparam logic [7:0] ADDR_TIMER_EN = 8'h02;
    localparam logic [7:0] ADDR_TIMER_FLAG = 8'h03;
    localparam logic [7:0] ADDR_MISC_EN = 8'h04;
    localparam logic [7:0] ADDR_MISC_FLAG = 8'h05;
    localparam logic [7:0] ADDR_TIMEBASE = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h07;
    localparam int NUM_GROUPS = 3;
    localparam int NUM_TIMERS = 2;
    // Group membership: groups 0 and 1 hold timers 0 and 1; group 2 holds low-supply and nvm write
    localparam int MISC_CONV = 0;
    localparam int MISC_NVM = 1;
    localparam int MISC_LOW = 2;
    localparam int MISC_TB0 = 3;
    localparam int MISC_TB1 = 4;
    localparam logic [7:0] TIMEBASE_RESET = 8'h37;
    localparam logic [7:0] TIMEBASE_MASK = 8'hf7;
    localparam int TB_RUN_BIT = 7;
    // Vector indices, lowest first wins
    localparam logic [2:0] VEC_TB0 = 3'h0;
    localparam logic [2:0] VEC_TB1 = 3'h1;
    localparam logic [2:0] VEC_GRP0 = 3'h2;
    localparam logic [2:0] VEC_CONV = 3'h3;
    localparam logic [2:0] VEC_GRP1 = 3'h4;
    localparam logic [2:0] VEC_GRP2 = 3'h5;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ===== mfic_ctrl.sv
// Interrupt request, vector and wake-up logic
`timescale 1ns/100ps
module mfic_ctrl (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] timer_p_match,
    input wire logic [1:0] timer_a_match,
    input wire logic conv_done,
    input wire logic nvm_write_end,
    input wire logic low_supply,
    input wire logic timebase0_ovf,
    input wire logic timebase1_ovf,
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic interrupt_exit_instr,
    input wire logic subroutine_exit_instr,
    output logic irq_req,
    output logic [2:0] irq_vector,
    output logic push_pc,
    output logic wake_up
);
    logic global_irq_enable_q;
    logic [2:0] group_irq_enable_q;
    logic [2:0] group_request_flags_q;
    logic [1:0] timer_p_match_enable_q;
    logic [1:0] timer_a_match_enable_q;
    logic [1:0] timer_p_match_flag_q;
    logic [1:0] timer_a_match_flag_q;
    logic conv_irq_enable_q, nvm_write_irq_enable_q, low_supply_irq_enable_q;
    logic tb0_irq_enable_q, tb1_irq_enable_q;
    logic conv_done_flag_q, nvm_write_done_flag_q, low_supply_flag_q;
    logic timebase0_flag_q, timebase1_flag_q;
    logic [7:0] timebase_control_q;
    logic [7:0] reg_rdata_q;
    logic irq_req_q, push_pc_q, wake_up_q;
    logic [2:0] irq_vector_q;
    logic [11:0] all_flags_q;
    logic low_supply_s1_q, low_supply_s2_q;

    // Write strobe decode, shared by every register except the read-only status word
    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] at);
        return wr && a == at;
    endfunction

    wire logic wr_global = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_GLOBAL);
    wire logic wr_group = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_GROUP);
    wire logic wr_timer_en = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_TIMER_EN);
    wire logic wr_timer_flag = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_TIMER_FLAG);
    wire logic wr_misc_en = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_MISC_EN);
    wire logic wr_misc_flag = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_MISC_FLAG);
    wire logic wr_timebase = wr_hit(reg_wr, reg_addr, mfic_pkg::ADDR_TIMEBASE);

    // Member requests that are enabled feed their group
    wire logic [1:0] timer_hit = (timer_p_match_flag_q & timer_p_match_enable_q)
        | (timer_a_match_flag_q & timer_a_match_enable_q);
    wire logic misc_hit = (nvm_write_done_flag_q & nvm_write_irq_enable_q)
        | (low_supply_flag_q & low_supply_irq_enable_q);
    wire logic [2:0] group_set = {misc_hit, timer_hit};

    // Pending vectors in index order
    wire logic [5:0] pend;
    assign pend[mfic_pkg::VEC_TB0] = timebase0_flag_q && tb0_irq_enable_q;
    assign pend[mfic_pkg::VEC_TB1] = timebase1_flag_q && tb1_irq_enable_q;
    assign pend[mfic_pkg::VEC_GRP0] = group_request_flags_q[0] && group_irq_enable_q[0];
    assign pend[mfic_pkg::VEC_CONV] = conv_done_flag_q && conv_irq_enable_q;
    assign pend[mfic_pkg::VEC_GRP1] = group_request_flags_q[1] && group_irq_enable_q[1];
    assign pend[mfic_pkg::VEC_GRP2] = group_request_flags_q[2] && group_irq_enable_q[2];
    // Stack full holds off a new request until the pointer drops
    wire logic can_take = global_irq_enable_q && !stack_full && !push_pc_q;

    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    wire logic [2:0] sel_vec = first_set(pend);
    wire logic take = irq_req_q && irq_ack;
    wire logic [5:0] svc = take ? (6'h01 << irq_vector_q) : 6'h00;
    wire logic arm = !irq_req_q && can_take && pend != 6'h00;

    // Set wins over clear for every flag
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic wr, input logic wbit, input logic svc_clr);
        logic r;
        r = cur;
        if (wr) begin
            r = wbit;
        end
        if (svc_clr) begin
            r = 1'b0;
        end
        if (set) begin
            r = 1'b1;
        end
        return r;
    endfunction

    wire logic [11:0] all_flags = {timebase1_flag_q, timebase0_flag_q, low_supply_flag_q,
        nvm_write_done_flag_q, conv_done_flag_q, group_request_flags_q,
        timer_a_match_flag_q, timer_p_match_flag_q};

    // One named word per readable register except time base control, read straight from its flops
    wire logic [7:0] rd_global = {7'h00, global_irq_enable_q};
    wire logic [7:0] rd_group = {1'b0, group_request_flags_q, 1'b0, group_irq_enable_q};
    wire logic [7:0] rd_timer_en = {4'h0, timer_a_match_enable_q, timer_p_match_enable_q};
    wire logic [7:0] rd_timer_flag = {4'h0, timer_a_match_flag_q, timer_p_match_flag_q};
    wire logic [7:0] rd_misc_en = {3'h0, tb1_irq_enable_q, tb0_irq_enable_q,
        low_supply_irq_enable_q, nvm_write_irq_enable_q, conv_irq_enable_q};
    wire logic [7:0] rd_misc_flag = {3'h0, timebase1_flag_q, timebase0_flag_q,
        low_supply_flag_q, nvm_write_done_flag_q, conv_done_flag_q};
    wire logic [7:0] rd_status = {1'b0, irq_vector_q, 2'h0, push_pc_q, irq_req_q};

    // Unmapped offsets read as zero so software never sees a stale word
    wire logic [7:0] rd_mux =
        reg_addr == mfic_pkg::ADDR_GLOBAL ? rd_global :
        reg_addr == mfic_pkg::ADDR_GROUP ? rd_group :
        reg_addr == mfic_pkg::ADDR_TIMER_EN ? rd_timer_en :
        reg_addr == mfic_pkg::ADDR_TIMER_FLAG ? rd_timer_flag :
        reg_addr == mfic_pkg::ADDR_MISC_EN ? rd_misc_en :
        reg_addr == mfic_pkg::ADDR_MISC_FLAG ? rd_misc_flag :
        reg_addr == mfic_pkg::ADDR_TIMEBASE ? timebase_control_q :
        reg_addr == mfic_pkg::ADDR_STATUS ? rd_status :
        mfic_pkg::ZERO_BYTE;

    // Detector output is asynchronous to this clock
    always_ff @(posedge ref_clk) begin
        low_supply_s1_q <= low_supply;
        low_supply_s2_q <= low_supply_s1_q;
    end

    // Service wins over an exit instruction or a write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            global_irq_enable_q <= 1'b0;
        end else if (take) begin
            global_irq_enable_q <= 1'b0;
        end else if (interrupt_exit_instr) begin
            global_irq_enable_q <= 1'b1;
        end else if (subroutine_exit_instr) begin
            global_irq_enable_q <= global_irq_enable_q;
        end else if (wr_global) begin
            global_irq_enable_q <= reg_wdata[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            group_irq_enable_q <= 3'h0;
        end else if (wr_group) begin
            group_irq_enable_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer_p_match_enable_q <= 2'h0;
            timer_a_match_enable_q <= 2'h0;
        end else if (wr_timer_en) begin
            timer_p_match_enable_q <= reg_wdata[1:0];
            timer_a_match_enable_q <= reg_wdata[3:2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {tb1_irq_enable_q, tb0_irq_enable_q, low_supply_irq_enable_q} <= 3'h0;
            {nvm_write_irq_enable_q, conv_irq_enable_q} <= 2'h0;
        end else if (wr_misc_en) begin
            {tb1_irq_enable_q, tb0_irq_enable_q, low_supply_irq_enable_q,
             nvm_write_irq_enable_q, conv_irq_enable_q} <= reg_wdata[4:0];
        end
    end

    // Bit 3 is not built here and always reads zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timebase_control_q <= mfic_pkg::TIMEBASE_RESET;
        end else if (wr_timebase) begin
            timebase_control_q <= reg_wdata & mfic_pkg::TIMEBASE_MASK;
        end
    end

    // Member flags only clear by software write; enable writes never touch them
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer_p_match_flag_q <= 2'h0;
            timer_a_match_flag_q <= 2'h0;
        end else begin
            for (int i = 0; i < mfic_pkg::NUM_TIMERS; i++) begin
                timer_p_match_flag_q[i] <= flag_next(timer_p_match_flag_q[i],
                    timer_p_match[i], wr_timer_flag, reg_wdata[i], 1'b0);
                timer_a_match_flag_q[i] <= flag_next(timer_a_match_flag_q[i],
                    timer_a_match[i], wr_timer_flag, reg_wdata[i+2], 1'b0);
            end
        end
    end

    // Group flags re-arm each cycle a member stays set and enabled,
    // so software must clear the member before the group falls for good
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            group_request_flags_q <= 3'h0;
        end else begin
            group_request_flags_q[0] <= flag_next(group_request_flags_q[0], group_set[0],
                wr_group, reg_wdata[4], svc[mfic_pkg::VEC_GRP0]);
            group_request_flags_q[1] <= flag_next(group_request_flags_q[1], group_set[1],
                wr_group, reg_wdata[5], svc[mfic_pkg::VEC_GRP1]);
            group_request_flags_q[2] <= flag_next(group_request_flags_q[2], group_set[2],
                wr_group, reg_wdata[6], svc[mfic_pkg::VEC_GRP2]);
        end
    end

    // Converter flag has its own vector and clears on service
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            conv_done_flag_q <= 1'b0;
        end else begin
            conv_done_flag_q <= flag_next(conv_done_flag_q, conv_done,
                wr_misc_flag, reg_wdata[mfic_pkg::MISC_CONV], svc[mfic_pkg::VEC_CONV]);
        end
    end

    // Nvm flag stays until software clears it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvm_write_done_flag_q <= 1'b0;
        end else begin
            nvm_write_done_flag_q <= flag_next(nvm_write_done_flag_q, nvm_write_end,
                wr_misc_flag, reg_wdata[mfic_pkg::MISC_NVM], 1'b0);
        end
    end

    // A clear while the supply is still low has no effect, as the synchronised level sets the flag in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            low_supply_flag_q <= 1'b0;
        end else begin
            low_supply_flag_q <= flag_next(low_supply_flag_q, low_supply_s2_q,
                wr_misc_flag, reg_wdata[mfic_pkg::MISC_LOW], 1'b0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timebase0_flag_q <= 1'b0;
        end else begin
            timebase0_flag_q <= flag_next(timebase0_flag_q, timebase0_ovf,
                wr_misc_flag, reg_wdata[mfic_pkg::MISC_TB0], svc[mfic_pkg::VEC_TB0]);
        end
    end

    // Second time base overflow only sets its flag while its run bit is set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timebase1_flag_q <= 1'b0;
        end else begin
            timebase1_flag_q <= flag_next(timebase1_flag_q,
                timebase1_ovf && timebase_control_q[mfic_pkg::TB_RUN_BIT],
                wr_misc_flag, reg_wdata[mfic_pkg::MISC_TB1], svc[mfic_pkg::VEC_TB1]);
        end
    end

    // Request held until the core acknowledges
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_req_q <= 1'b0;
        end else if (take) begin
            irq_req_q <= 1'b0;
        end else if (arm) begin
            irq_req_q <= 1'b1;
        end
    end

    // Vector latched with the request; a later source waits for the next turn
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_vector_q <= 3'h0;
        end else if (arm) begin
            irq_vector_q <= sel_vec;
        end
    end

    // Only the program counter is saved; the core keeps everything else
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            push_pc_q <= 1'b0;
        end else begin
            push_pc_q <= take;
        end
    end

    // Flags preset high cannot rise, so they cannot wake the device
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            all_flags_q <= 12'h000;
            wake_up_q <= 1'b0;
        end else begin
            all_flags_q <= all_flags;
            wake_up_q <= |(all_flags & ~all_flags_q);
        end
    end

    // Read data stands one cycle and is zero otherwise
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata_q <= mfic_pkg::ZERO_BYTE;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : mfic_pkg::ZERO_BYTE;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign irq_req = irq_req_q;
    assign irq_vector = irq_vector_q;
    assign push_pc = push_pc_q;
    assign wake_up = wake_up_q;
endmodule // mfic_ctrl

// ===== mfic_ctrl_chk.sv
// Checker of request, service and bus timing
`timescale 1ns/100ps
module mfic_ctrl_chk (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic interrupt_exit_instr,
    input wire logic irq_req,
    input wire logic [2:0] irq_vector,
    input wire logic push_pc
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_take;
        irq_req && irq_ack && !interrupt_exit_instr && !reg_wr;
    endsequence
    sequence s_calm;
        (!interrupt_exit_instr && !reg_wr) [*3];
    endsequence
    chk_take_push: assert property (irq_req && irq_ack |=> push_pc && !irq_req)
        else $error("no push after ack");
    chk_push_cause: assert property (push_pc |-> $past(irq_req && irq_ack))
        else $error("push without ack");
    chk_stack_block: assert property (stack_full && !irq_req |=> !irq_req)
        else $error("request with stack full");
    chk_vec_hold: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_vector))
        else $error("request dropped or vector moved");
    chk_req_drop: assert property ($fell(irq_req) |-> $past(irq_ack) || $past(srst))
        else $error("request fell without ack");
    chk_global_off: assert property (s_take ##1 s_calm |=> !irq_req)
        else $error("request while global enable off");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_vec_range: assert property (irq_req |-> irq_vector <= mfic_pkg::VEC_GRP2)
        else $error("vector out of range");
endmodule // mfic_ctrl_chk

bind mfic_ctrl mfic_ctrl_chk u_chk (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stack_full(stack_full), .irq_ack(irq_ack),
    .interrupt_exit_instr(interrupt_exit_instr), .irq_req(irq_req),
    .irq_vector(irq_vector), .push_pc(push_pc));

// ===== mfic_core_model.sv
// Behavioural core sequencer that takes interrupt requests
`timescale 1ns/100ps
module mfic_core_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic irq_req,
    input wire logic [3:0] ack_wait,
    output logic irq_ack
);
    logic [3:0] wait_q;
    logic ack_q;
    assign irq_ack = ack_q;
    // Variable wait so both prompt and slow cores are seen
    always_ff @(posedge ref_clk) begin
        if (srst || !irq_req || ack_q) begin
            wait_q <= 4'h0;
            ack_q <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            ack_q <= (wait_q >= ack_wait);
        end
    end
endmodule // mfic_core_model

// ===== mfic_ctrl_bench.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
module mfic_ctrl_bench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, stack_full = 1'b0, low_supply = 1'b0;
    logic irq_ack, irq_req, push_pc, wake_up;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [9:0] evt = 10'h000;
    logic [2:0] irq_vector;
    logic [3:0] ack_wait = 4'h0;
    int n_fail, samples_checked, n_wake;
    mfic_ctrl dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_p_match(evt[1:0]),
        .timer_a_match(evt[3:2]), .conv_done(evt[4]), .nvm_write_end(evt[5]),
        .low_supply(low_supply), .timebase0_ovf(evt[6]), .timebase1_ovf(evt[7]),
        .stack_full(stack_full), .irq_ack(irq_ack), .interrupt_exit_instr(evt[8]),
        .subroutine_exit_instr(evt[9]), .irq_req(irq_req), .irq_vector(irq_vector),
        .push_pc(push_pc), .wake_up(wake_up));
    mfic_core_model core (.ref_clk(ref_clk), .srst(srst), .irq_req(irq_req),
        .ack_wait(ack_wait), .irq_ack(irq_ack));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (wake_up === 1'b1) n_wake++;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task automatic pulse(input logic [9:0] m);
        @(posedge ref_clk);
        evt <= m;
        @(posedge ref_clk);
        evt <= 10'h000;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Waits are bounded so a missing request cannot hang the run
    task automatic serve(input logic [2:0] v);
        int i;
        #1;
        for (i = 0; i < 40 && irq_req !== 1'b1; i++) @(posedge ref_clk) #1;
        chk("irq_req", 8'h01, {7'h00, irq_req});
        chk("irq_vector", {5'h00, v}, {5'h00, irq_vector});
        for (i = 0; i < 40 && push_pc !== 1'b1; i++) @(posedge ref_clk) #1;
        chk("push_pc", 8'h01, {7'h00, push_pc});
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        close_out;
    end
    initial begin
        int w;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd(8'h06, 8'h37);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'hf7);
        rd(8'hff, 8'h00);
        wr(8'h00, 8'h01);
        wr(8'h04, 8'h01);
        w = n_wake;
        pulse(10'h010);
        serve(mfic_pkg::VEC_CONV);
        chk("wake", 8'(w + 1), 8'(n_wake));
        rd(8'h05, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h02, 8'h01);
        wr(8'h01, 8'h01);
        pulse(10'h001);
        tick(4);
        chk("held irq_req", 8'h00, {7'h00, irq_req});
        rd(8'h03, 8'h01);
        rd(8'h01, 8'h11);
        ack_wait <= 4'h3;
        pulse(10'h100);
        serve(mfic_pkg::VEC_GRP0);
        rd(8'h03, 8'h01);
        rd(8'h00, 8'h00);
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h01);
        rd(8'h01, 8'h01);
        pulse(10'h200);
        tick(3);
        rd(8'h00, 8'h00);
        wr(8'h04, 8'h0b);
        wr(8'h01, 8'h04);
        pulse(10'h070);
        stack_full <= 1'b1;
        wr(8'h00, 8'h01);
        tick(4);
        chk("full irq_req", 8'h00, {7'h00, irq_req});
        stack_full <= 1'b0;
        serve(mfic_pkg::VEC_TB0);
        pulse(10'h100);
        serve(mfic_pkg::VEC_CONV);
        pulse(10'h100);
        serve(mfic_pkg::VEC_GRP2);
        rd(8'h05, 8'h02);
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h00);
        wr(8'h01, 8'h00);
        w = n_wake;
        low_supply <= 1'b1;
        tick(8);
        chk("wake", 8'(w + 1), 8'(n_wake));
        rd(8'h05, 8'h04);
        wr(8'h05, 8'h06);
        tick(3);
        w = n_wake;
        pulse(10'h020);
        tick(4);
        chk("wake", 8'(w), 8'(n_wake));
        close_out;
    end
endmodule // mfic_ctrl_bench
